/* opdec_consts.vh */
// Constants for the operand addressing decoder
`ifndef OPDEC_CONSTS_VH
`define OPDEC_CONSTS_VH

// ----------------------------------------------------------------
// Control registers inside the register file (register index)
// ----------------------------------------------------------------
`define OPDEC_IDX_INT_MASK 8'hFB
`define OPDEC_IDX_FLAGS 8'hFC
`define OPDEC_IDX_BANK_PTR 8'hFD
`define OPDEC_RST_INT_MASK 8'h00
`define OPDEC_RST_FLAGS 8'h00
`define OPDEC_RST_BANK_PTR 8'h00

// ----------------------------------------------------------------
// Decoder result registers (register index, byte address = 4 x index)
// ----------------------------------------------------------------
`define OPDEC_IDX_STATUS 8'h00
`define OPDEC_IDX_SRC 8'h01
`define OPDEC_IDX_DST 8'h02
`define OPDEC_IDX_TARGET 8'h03
`define OPDEC_IDX_IMM 8'h04
`define OPDEC_IDX_RF_SIZE 8'h05

// Status register bit positions
`define OPDEC_ST_BUSY 0
`define OPDEC_ST_COND 1
`define OPDEC_ST_PAIR_ERR 2
`define OPDEC_ST_RANGE_ERR 3

// ----------------------------------------------------------------
// Flag bit positions and field layouts
// ----------------------------------------------------------------
`define OPDEC_FLAG_C 7
`define OPDEC_FLAG_Z 6
`define OPDEC_FLAG_S 5
`define OPDEC_FLAG_V 4
`define OPDEC_WREG_PREFIX 4'hE
`define OPDEC_CTRL_BASE 8'hF0
`define OPDEC_RF_FULL 9'h100

// ----------------------------------------------------------------
// Operand formats
// ----------------------------------------------------------------
`define OPDEC_FMT_NONE 3'h0
`define OPDEC_FMT_REG 3'h1
`define OPDEC_FMT_REG_REG 3'h2
`define OPDEC_FMT_REG_IM 3'h3
`define OPDEC_FMT_PAIR 3'h4
`define OPDEC_FMT_INDEXED 3'h5
`define OPDEC_FMT_DIRECT 3'h6
`define OPDEC_FMT_RELATIVE 3'h7

`endif

/* opdec_cond_eval.v */
// Branch condition evaluator for the operand addressing decoder
`timescale 1ns/1ps
`include "opdec_consts.vh"

module opdec_cond_eval
(
  input wire [3:0] cond_in,
  input wire [7:0] flags_in,
  output reg true_out
);

  wire c_flag;
  wire z_flag;
  wire s_flag;
  wire v_flag;
  reg base_test;

  assign c_flag = flags_in[`OPDEC_FLAG_C];
  assign z_flag = flags_in[`OPDEC_FLAG_Z];
  assign s_flag = flags_in[`OPDEC_FLAG_S];
  assign v_flag = flags_in[`OPDEC_FLAG_V];

  // Upper bit of the selector inverts the test chosen by the low three
  always @*
  begin
    base_test = 1'b0;
    case (cond_in[2:0])
      3'h0: base_test = 1'b0;
      3'h1: base_test = s_flag ^ v_flag;
      3'h2: base_test = z_flag | (s_flag ^ v_flag);
      3'h3: base_test = c_flag | z_flag;
      3'h4: base_test = v_flag;
      3'h5: base_test = s_flag;
      3'h6: base_test = z_flag;
      3'h7: base_test = c_flag;
      default: base_test = 1'b0;
    endcase
    true_out = base_test ^ cond_in[3];
  end

endmodule

/* opdec_top.v */
// Operand addressing decoder with Avalon-MM register access
//
// Overview of operation
// - An 8-bit register field selects any of 256 locations, or a working register via the Eh prefix.
// - Pair operands must resolve to an even address, or one of the even working registers 0 to 14.
// - A relative offset is a signed -128..+127 displacement added to the next instruction address.
// - An immediate operand is the 8-bit literal byte taken straight from the instruction stream.
// - Indexed mode pairs an 8-bit base address with a working register picked by a 4-bit field.
// - A direct target byte is passed out unchanged as the target address.
// - Interrupt mask, flags and bank pointer sit at FBh, FCh, FDh and answer to register operands.
// - Two-register instructions arrive as opcode byte, then source byte, then destination byte.
// - The implemented register file size is a parameter and decode flags addresses beyond it, except the F0h to FFh control region.
// - Conditional instructions carry a 4-bit condition selector in opcode bits 7 to 4.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "opdec_consts.vh"

module opdec_top
#(
  parameter RF_SIZE = 256
)
(
  input wire clk_in,
  input wire rst_in,
  // Avalon-MM slave
  input wire [9:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // Instruction byte stream
  input wire [7:0] instr_byte_in,
  input wire instr_valid_in,
  input wire [2:0] fmt_in,
  input wire [15:0] next_pc_in,
  output reg instr_ready_out,
  // Register file read port, data valid the cycle after the enable
  output reg rf_rd_en_out,
  output reg [7:0] rf_rd_addr_out,
  input wire [7:0] rf_rd_data_in,
  // Decode results
  output reg done_out,
  output reg [7:0] src_addr_out,
  output reg [7:0] dst_addr_out,
  output reg [7:0] imm_out,
  output reg [15:0] target_out,
  output reg [3:0] cond_code_out,
  output reg cond_true_out,
  output reg pair_err_out,
  output reg range_err_out,
  // Control registers toward the core
  output reg [7:0] int_mask_out,
  output reg [7:0] flags_out,
  output reg [7:0] bank_ptr_out
);

  // ----------------------------------------------------------------
  // Decode states
  // ----------------------------------------------------------------
  localparam ST_OPC = 3'h0;
  localparam ST_BYTE1 = 3'h1;
  localparam ST_BYTE2 = 3'h2;
  localparam ST_XWAIT = 3'h3;
  localparam ST_XCAP = 3'h4;
  localparam ST_DONE = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] fmt_reg;
  reg [7:0] opcode_reg;
  reg [7:0] byte1_reg;
  reg [15:0] pc_reg;
  reg [7:0] int_mask_reg;
  reg [7:0] flags_reg;
  reg [7:0] bank_ptr_reg;
  wire [7:0] req_index;
  wire req_any;
  wire cond_now;
  wire byte_take;

  // ----------------------------------------------------------------
  // Operand helpers
  // ----------------------------------------------------------------
  // Eh in the upper nibble names a working register in the current bank
  function [7:0] resolve_reg;
    input [7:0] field;
    input [7:0] bank;
    begin
      if (field[7:4] == `OPDEC_WREG_PREFIX)
        resolve_reg = {bank[7:4], field[3:0]};
      else
        resolve_reg = field;
    end
  endfunction

  function [7:0] resolve_wreg;
    input [3:0] num;
    input [7:0] bank;
    begin
      resolve_wreg = {bank[7:4], num};
    end
  endfunction

  // Control region stays reachable even on devices with a small file
  function out_of_range;
    input [7:0] addr;
    begin
      out_of_range = ({1'b0, addr} >= RF_SIZE[8:0]) && (addr < `OPDEC_CTRL_BASE);
    end
  endfunction

  opdec_cond_eval u_cond
  (
    .cond_in(opcode_reg[7:4]),
    .flags_in(flags_reg),
    .true_out(cond_now)
  );

  assign byte_take = instr_valid_in && instr_ready_out;

  // ----------------------------------------------------------------
  // Decode sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= ST_OPC;
      fmt_reg <= `OPDEC_FMT_NONE;
      opcode_reg <= 8'h00;
      byte1_reg <= 8'h00;
      pc_reg <= 16'h0000;
      instr_ready_out <= 1'b0;
      rf_rd_en_out <= 1'b0;
      rf_rd_addr_out <= 8'h00;
      done_out <= 1'b0;
      src_addr_out <= 8'h00;
      dst_addr_out <= 8'h00;
      imm_out <= 8'h00;
      target_out <= 16'h0000;
      cond_code_out <= 4'h0;
      cond_true_out <= 1'b0;
      pair_err_out <= 1'b0;
      range_err_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      rf_rd_en_out <= 1'b0;
      case (state_reg)
        ST_OPC:
        begin
          instr_ready_out <= 1'b1;
          if (byte_take)
          begin
            opcode_reg <= instr_byte_in;
            fmt_reg <= fmt_in;
            pc_reg <= next_pc_in;
            cond_code_out <= instr_byte_in[7:4];
            pair_err_out <= 1'b0;
            range_err_out <= 1'b0;
            if (fmt_in == `OPDEC_FMT_NONE)
            begin
              instr_ready_out <= 1'b0;
              state_reg <= ST_DONE;
            end
            else
              state_reg <= ST_BYTE1;
          end
        end
        ST_BYTE1:
        begin
          if (byte_take)
          begin
            byte1_reg <= instr_byte_in;
            state_reg <= ST_BYTE2;
            case (fmt_reg)
              `OPDEC_FMT_REG:
              begin
                dst_addr_out <= resolve_reg(instr_byte_in, bank_ptr_reg);
                range_err_out <= out_of_range(resolve_reg(instr_byte_in, bank_ptr_reg));
                instr_ready_out <= 1'b0;
                state_reg <= ST_DONE;
              end
              `OPDEC_FMT_REG_REG:
              begin
                // Source byte precedes the destination byte
                src_addr_out <= resolve_reg(instr_byte_in, bank_ptr_reg);
                range_err_out <= out_of_range(resolve_reg(instr_byte_in, bank_ptr_reg));
              end
              `OPDEC_FMT_REG_IM:
              begin
                dst_addr_out <= resolve_reg(instr_byte_in, bank_ptr_reg);
                range_err_out <= out_of_range(resolve_reg(instr_byte_in, bank_ptr_reg));
              end
              `OPDEC_FMT_PAIR:
              begin
                dst_addr_out <= resolve_reg(instr_byte_in, bank_ptr_reg);
                pair_err_out <= instr_byte_in[0];
                range_err_out <= out_of_range(resolve_reg(instr_byte_in, bank_ptr_reg));
                instr_ready_out <= 1'b0;
                state_reg <= ST_DONE;
              end
              `OPDEC_FMT_INDEXED:
              begin
                // High nibble: data register, low nibble: index register
                dst_addr_out <= resolve_wreg(instr_byte_in[7:4], bank_ptr_reg);
              end
              `OPDEC_FMT_DIRECT:
              begin
                target_out <= {8'h00, instr_byte_in};
                instr_ready_out <= 1'b0;
                state_reg <= ST_DONE;
              end
              `OPDEC_FMT_RELATIVE:
              begin
                target_out <= pc_reg + {{8{instr_byte_in[7]}}, instr_byte_in};
                cond_true_out <= cond_now;
                instr_ready_out <= 1'b0;
                state_reg <= ST_DONE;
              end
              default:
              begin
                instr_ready_out <= 1'b0;
                state_reg <= ST_DONE;
              end
            endcase
          end
        end
        ST_BYTE2:
        begin
          if (byte_take)
          begin
            instr_ready_out <= 1'b0;
            state_reg <= ST_DONE;
            case (fmt_reg)
              `OPDEC_FMT_REG_REG:
              begin
                dst_addr_out <= resolve_reg(instr_byte_in, bank_ptr_reg);
                range_err_out <= range_err_out |
                  out_of_range(resolve_reg(instr_byte_in, bank_ptr_reg));
              end
              `OPDEC_FMT_REG_IM:
                imm_out <= instr_byte_in;
              `OPDEC_FMT_INDEXED:
              begin
                // Base byte is kept; the index register must be fetched first
                imm_out <= instr_byte_in;
                rf_rd_en_out <= 1'b1;
                rf_rd_addr_out <= resolve_wreg(byte1_reg[3:0], bank_ptr_reg);
                state_reg <= ST_XWAIT;
              end
              default:
                state_reg <= ST_DONE;
            endcase
          end
        end
        ST_XWAIT:
          state_reg <= ST_XCAP;
        ST_XCAP:
        begin
          src_addr_out <= imm_out + rf_rd_data_in;
          range_err_out <= out_of_range(imm_out + rf_rd_data_in);
          state_reg <= ST_DONE;
        end
        ST_DONE:
        begin
          done_out <= 1'b1;
          instr_ready_out <= 1'b1;
          state_reg <= ST_OPC;
        end
        default:
        begin
          instr_ready_out <= 1'b0;
          state_reg <= ST_OPC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle per access: read data is registered at the same edge that drops waitrequest
  assign req_index = avs_address_in[9:2];
  assign req_any = avs_read_in || avs_write_in;

  function [31:0] read_mux;
    input [7:0] idx;
    input [31:0] status_word;
    begin
      case (idx)
        `OPDEC_IDX_STATUS: read_mux = status_word;
        `OPDEC_IDX_SRC: read_mux = {24'h0000_00, src_addr_out};
        `OPDEC_IDX_DST: read_mux = {24'h0000_00, dst_addr_out};
        `OPDEC_IDX_TARGET: read_mux = {16'h0000, target_out};
        `OPDEC_IDX_IMM: read_mux = {24'h0000_00, imm_out};
        `OPDEC_IDX_RF_SIZE: read_mux = {23'h0000_00, RF_SIZE[8:0]};
        `OPDEC_IDX_INT_MASK: read_mux = {24'h0000_00, int_mask_reg};
        `OPDEC_IDX_FLAGS: read_mux = {24'h0000_00, flags_reg};
        `OPDEC_IDX_BANK_PTR: read_mux = {24'h0000_00, bank_ptr_reg};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  wire [31:0] status_word;
  assign status_word = {28'h000_0000, range_err_out, pair_err_out, cond_true_out,
    (state_reg != ST_OPC)};

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      int_mask_reg <= `OPDEC_RST_INT_MASK;
      flags_reg <= `OPDEC_RST_FLAGS;
      bank_ptr_reg <= `OPDEC_RST_BANK_PTR;
      int_mask_out <= `OPDEC_RST_INT_MASK;
      flags_out <= `OPDEC_RST_FLAGS;
      bank_ptr_out <= `OPDEC_RST_BANK_PTR;
    end
    else
    begin
      int_mask_out <= int_mask_reg;
      flags_out <= flags_reg;
      bank_ptr_out <= bank_ptr_reg;
      if (req_any && avs_waitrequest_out)
      begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out <= avs_read_in ? read_mux(req_index, status_word) : 32'h0000_0000;
      end
      else
      begin
        avs_waitrequest_out <= 1'b1;
        // Write lands at the edge where the master sees waitrequest low
        if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0])
        begin
          case (req_index)
            `OPDEC_IDX_INT_MASK: int_mask_reg <= avs_writedata_in[7:0];
            `OPDEC_IDX_FLAGS: flags_reg <= avs_writedata_in[7:0];
            `OPDEC_IDX_BANK_PTR: bank_ptr_reg <= avs_writedata_in[7:0];
            default: int_mask_reg <= int_mask_reg;
          endcase
        end
      end
    end
  end

endmodule

/* oad_checker.sv */
// Concurrent checks on the operand decoder bus, stream and control ports
`timescale 1ns/1ps
module oad_checker
(
  input wire clk_in,
  input wire rst_in,
  input wire [9:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire instr_ready_out,
  input wire rf_rd_en_out,
  input wire done_out,
  input wire [7:0] int_mask_out,
  input wire [7:0] flags_out,
  input wire [7:0] bank_ptr_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire req = avs_read_in || avs_write_in;
  wire wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire [7:0] idx = avs_address_in[9:2];

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  bus_answer_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer not after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer without request");
  read_upper_a: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  mask_copy_a: assert property (wr_ok && idx == 8'hfb |->
    ##2 int_mask_out == $past(avs_writedata_in[7:0], 2))
    else $error("interrupt mask output not updated");
  flag_copy_a: assert property (wr_ok && idx == 8'hfc |->
    ##2 flags_out == $past(avs_writedata_in[7:0], 2))
    else $error("flag output not updated");
  bank_copy_a: assert property (wr_ok && idx == 8'hfd |->
    ##2 bank_ptr_out == $past(avs_writedata_in[7:0], 2))
    else $error("bank pointer output not updated");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  done_ready_a: assert property (done_out |-> $past(instr_ready_out) == 1'b0)
    else $error("stream accepted bytes before done");
  rd_pulse_a: assert property (rf_rd_en_out |=> !rf_rd_en_out)
    else $error("register file read longer than one cycle");
endmodule

bind opdec_top oad_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .instr_ready_out(instr_ready_out), .rf_rd_en_out(rf_rd_en_out), .done_out(done_out),
  .int_mask_out(int_mask_out), .flags_out(flags_out), .bank_ptr_out(bank_ptr_out));

/* operand_addressing_decode_bench.sv */
// Self-checking bench for the operand addressing decoder
`timescale 1ns/1ps
module operand_addressing_decode_bench;
  logic clk_in = 0;
  logic rst_in = 1;
  logic [9:0] avs_address_in = 0;
  logic avs_read_in = 0;
  logic avs_write_in = 0;
  logic [31:0] avs_writedata_in = 0;
  logic [3:0] avs_byteenable_in = 0;
  logic [7:0] instr_byte_in = 0;
  logic instr_valid_in = 0;
  logic [2:0] fmt_in = 0;
  logic [15:0] next_pc_in = 0;
  logic [7:0] rf_rd_data_in = 0;
  logic [7:0] last_rf = 0;
  logic [31:0] rd;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, instr_ready_out, rf_rd_en_out, done_out, cond_true_out;
  wire pair_err_out, range_err_out;
  wire [7:0] rf_rd_addr_out, src_addr_out, dst_addr_out, imm_out;
  wire [7:0] int_mask_out, flags_out, bank_ptr_out;
  wire [15:0] target_out;
  wire [3:0] cond_code_out;
  int failures = 0;
  int checks = 0;

  // Small register file so the range check has something to flag
  opdec_top #(.RF_SIZE(128)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .instr_byte_in(instr_byte_in), .instr_valid_in(instr_valid_in), .fmt_in(fmt_in),
    .next_pc_in(next_pc_in), .instr_ready_out(instr_ready_out), .rf_rd_en_out(rf_rd_en_out),
    .rf_rd_addr_out(rf_rd_addr_out), .rf_rd_data_in(rf_rd_data_in), .done_out(done_out),
    .src_addr_out(src_addr_out), .dst_addr_out(dst_addr_out), .imm_out(imm_out),
    .target_out(target_out), .cond_code_out(cond_code_out), .cond_true_out(cond_true_out),
    .pair_err_out(pair_err_out), .range_err_out(range_err_out), .int_mask_out(int_mask_out),
    .flags_out(flags_out), .bank_ptr_out(bank_ptr_out));

  always #50 clk_in = ~clk_in;

  // Register file stand-in: data held from the cycle after the read request
  always @(posedge clk_in)
    if (rf_rd_en_out)
    begin
      rf_rd_data_in <= rf_rd_addr_out + 8'h0d;
      last_rf <= rf_rd_addr_out;
    end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge that ends the access
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    input logic [3:0] be, output logic [31:0] q);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_writedata_in <= {24'h0, wd};
    avs_byteenable_in <= be;
    do
    begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 0;
    avs_write_in <= 0;
    @(posedge clk_in);
  endtask

  // Ready and done are registers, looked at on the falling edge once settled
  task automatic decode(input logic [2:0] f, input logic [15:0] pc, input logic [23:0] b,
    input int n);
    int k;
    logic r;
    for (k = 0; k < n; k++)
    begin
      instr_byte_in <= b[23-8*k -: 8];
      instr_valid_in <= 1;
      fmt_in <= f;
      next_pc_in <= pc;
      do
      begin
        @(negedge clk_in);
        r = instr_ready_out;
        @(posedge clk_in);
      end while (r !== 1'b1);
    end
    instr_valid_in <= 0;
    r = 0;
    for (k = 0; k < 20 && r !== 1'b1; k++)
    begin
      @(negedge clk_in);
      r = done_out;
    end
    chk("done", 1, r);
    @(posedge clk_in);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    int i;
    for (i = 0; i < 3; i++)
    begin
      bus(0, 8'hfb + i, 0, 4'h1, rd);
      chk("ctrl reset", 0, rd);
      bus(1, 8'hfb + i, 8'h5a + i, 4'h1, rd);
      bus(1, 8'hfb + i, 8'hff, 4'h0, rd);
      bus(0, 8'hfb + i, 0, 4'h1, rd);
      chk("ctrl readback", 8'h5a + i, rd);
    end
    chk("ctrl outputs", 24'h5a5b5c, {int_mask_out, flags_out, bank_ptr_out});
    bus(0, 8'h05, 0, 4'h1, rd);
    chk("size", 128, rd);
    bus(1, 8'h40, 8'h77, 4'h1, rd);
    bus(0, 8'h40, 0, 4'h1, rd);
    chk("unmapped", 0, rd);
    bus(1, 8'h01, 8'h33, 4'h1, rd);
    bus(0, 8'h01, 0, 4'h1, rd);
    chk("src read only", 0, rd);
  endtask

  task automatic t_regreg;
    bus(1, 8'hfd, 8'h10, 4'h1, rd);
    decode(2, 0, 24'h04_0843, 3);
    chk("src", 8'h08, src_addr_out);
    chk("dst", 8'h43, dst_addr_out);
    bus(0, 8'h02, 0, 4'h1, rd);
    chk("dst reg", 8'h43, rd);
    decode(2, 0, 24'h04_e843, 3);
    chk("working src", 8'h18, src_addr_out);
    decode(2, 0, 24'h04_fcfd, 3);
    chk("ctrl operands", 16'hfcfd, {src_addr_out, dst_addr_out});
    chk("ctrl in range", 0, range_err_out);
  endtask

  task automatic t_range;
    decode(1, 0, 24'h01_9000, 2);
    chk("range high", 1, range_err_out);
    bus(0, 8'h00, 0, 4'h1, rd);
    chk("status range", 1, rd[3]);
    decode(1, 0, 24'h01_7f00, 2);
    chk("range edge", 0, range_err_out);
  endtask

  task automatic t_pair;
    logic [7:0] f [4] = '{8'h22, 8'h23, 8'he4, 8'hfe};
    int i;
    for (i = 0; i < 4; i++)
    begin
      decode(4, 0, {8'h80, f[i], 8'h00}, 2);
      chk("pair err", f[i][0], pair_err_out);
    end
  endtask

  task automatic t_misc;
    decode(3, 0, 24'h0c_43ff, 3);
    chk("imm", 16'h43ff, {dst_addr_out, imm_out});
    decode(6, 16'h1234, 24'hd6_fe00, 2);
    chk("direct", 16'h00fe, target_out);
    decode(5, 0, 24'h4f_23f0, 3);
    chk("index read", 8'h13, last_rf);
    chk("index src", 8'h10, src_addr_out);
    chk("index dst", 8'h12, dst_addr_out);
  endtask

  task automatic t_rel;
    logic [31:0] tv [4] = '{32'h8b7f_0001, 32'h0b80_0000, 32'h7b00_8001, 32'h7b01_0000};
    int i;
    for (i = 0; i < 4; i++)
    begin
      bus(1, 8'hfc, tv[i][15:8], 4'h1, rd);
      decode(7, 16'h1000, {tv[i][31:16], 8'h00}, 2);
      chk("rel target", 16'(16'h1000 + {{8{tv[i][23]}}, tv[i][23:16]}), target_out);
      chk("cond code", tv[i][31:28], cond_code_out);
      chk("cond true", tv[i][0], cond_true_out);
    end
  endtask

  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 0;
    repeat (2) @(posedge clk_in);
    t_regs;
    t_regreg;
    t_range;
    t_pair;
    t_misc;
    t_rel;
    summarize;
  end

  // Whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (6000) @(posedge clk_in);
    failures++;
    summarize;
  end
endmodule
